/* rtl/fan_commutation_lock_speed_ctrl.sv */
`timescale 1ns/1ps
// How it works
// - north field: coil A low, coil B high, speed pulse low.
// - south field: coil A high, coil B low, speed pulse released high.
// - hall state changes only on threshold crossing, otherwise held.
// - rotor locked beyond 0.3 s: stop driving both coils.
// - after lock shutdown wait 4.2 s, then drive again.
// - internal PWM carrier fixed at 25 kHz.
// - PWM on while command level exceeds 0.5-2.5 V ramp.
// - on-duty equals 50 times command minus 0.5, clamped 0-100 percent.
// - digital command pulse train averaged into a level first.
// - command open or above 2.5 V gives full duty.
// - command below 0.5 V over 25 ms stops motor, lock timing off.
// - command rising above 0.5 V from stop drives at once.
module fan_commutation_lock_speed_ctrl
  import fan_ctrl_pkg::*;
#(
  parameter int unsigned LOCK_DETECT_CYCLES = LOCK_DETECT_INTERVAL_MS * CYCLES_PER_MS,
  parameter int unsigned LOCK_OFF_CYCLES = LOCK_OFF_INTERVAL_MS * CYCLES_PER_MS,
  parameter int unsigned STANDBY_CYCLES = STANDBY_DELAY_MS * CYCLES_PER_MS
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic hall_south,
  input wire logic hall_north,
  input speed_cmd_t speed_cmd,
  output drive_out_t drive_out,
  output logic speed_pulse_oe,
  output logic coil_enable,
  output logic pwm_on
);

  localparam int unsigned TIMER_W = 26;
  localparam logic [TIMER_W-1:0] LOCK_DETECT_LAST = TIMER_W'(LOCK_DETECT_CYCLES - 1);
  localparam logic [TIMER_W-1:0] LOCK_OFF_LAST = TIMER_W'(LOCK_OFF_CYCLES - 1);
  localparam logic [TIMER_W-1:0] STANDBY_LAST = TIMER_W'(STANDBY_CYCLES - 1);

  logic field_south_q;
  logic field_south_d;
  logic field_prev_q;
  logic hall_edge;
  logic [AVG_W-1:0] avg_q;
  logic [LEVEL_W-1:0] avg_level;
  logic [LEVEL_W-1:0] cmd_level;
  logic cmd_low;
  logic [TIMER_W-1:0] low_cnt_q;
  logic standby_q;
  logic [TIMER_W-1:0] timer_q;
  drive_state_t state_q;
  logic on_phase;
  logic driving;

  // ----------------------------------------------------------------
  // hall hysteresis latch
  // ----------------------------------------------------------------
  always_comb begin
    field_south_d = field_south_q;
    if (hall_south && !hall_north) begin
      field_south_d = 1'b1;
    end else if (hall_north && !hall_south) begin
      field_south_d = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      field_south_q <= 1'b0;
      field_prev_q <= 1'b0;
    end else if (clk_en) begin
      field_south_q <= field_south_d;
      field_prev_q <= field_south_q;
    end
  end

  assign hall_edge = field_south_q ^ field_prev_q;

  // ----------------------------------------------------------------
  // speed command averaging
  // ----------------------------------------------------------------
  // first-order filter: avg += (x - avg) >> shift
  always_ff @(posedge clk) begin
    if (rst) begin
      avg_q <= {DIGITAL_HIGH_MV, AVG_SHIFT'(0)};
    end else if (clk_en) begin
      avg_q <= avg_q - AVG_W'(avg_q >> AVG_SHIFT)
        + AVG_W'(speed_cmd.digital_in ? DIGITAL_HIGH_MV : LEVEL_W'(0));
    end
  end

  assign avg_level = avg_q[AVG_W-1:AVG_SHIFT];

  always_comb begin
    cmd_level = speed_cmd.digital_mode ? avg_level : speed_cmd.level_mv;
    if (cmd_level > RAMP_HIGH_MV) begin
      cmd_level = RAMP_HIGH_MV;
    end
  end

  assign cmd_low = (cmd_level < RAMP_LOW_MV);

  // ----------------------------------------------------------------
  // standby detection
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      low_cnt_q <= '0;
      standby_q <= 1'b0;
    end else if (clk_en) begin
      if (!cmd_low) begin
        low_cnt_q <= '0;
        standby_q <= 1'b0;
      end else if (low_cnt_q == STANDBY_LAST) begin
        standby_q <= 1'b1;
      end else begin
        low_cnt_q <= low_cnt_q + TIMER_W'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // lock protection state machine
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ST_RUN;
      timer_q <= '0;
    end else if (clk_en) begin
      case (state_q)
        ST_STOP: begin
          timer_q <= '0;
          if (!standby_q) begin
            state_q <= ST_QUICK;
          end
        end
        ST_QUICK: begin
          timer_q <= '0;
          state_q <= ST_RUN;
        end
        ST_RUN: begin
          if (standby_q) begin
            state_q <= ST_STOP;
            timer_q <= '0;
          end else if (hall_edge) begin
            timer_q <= '0;
          end else if (timer_q == LOCK_DETECT_LAST) begin
            state_q <= ST_LOCK_OFF;
            timer_q <= '0;
          end else begin
            timer_q <= timer_q + TIMER_W'(1);
          end
        end
        ST_LOCK_OFF: begin
          if (standby_q) begin
            state_q <= ST_STOP;
            timer_q <= '0;
          end else if (timer_q == LOCK_OFF_LAST) begin
            state_q <= ST_RUN;
            timer_q <= '0;
          end else begin
            timer_q <= timer_q + TIMER_W'(1);
          end
        end
        default: begin
          state_q <= ST_RUN;
          timer_q <= '0;
        end
      endcase
    end
  end

  assign driving = (state_q == ST_RUN) || (state_q == ST_QUICK);

  // ----------------------------------------------------------------
  // carrier PWM
  // ----------------------------------------------------------------
  carrier_pwm u_carrier_pwm (
    .clk(clk),
    .rst(rst),
    .clk_en(clk_en),
    .level_mv(cmd_level),
    .on_phase(on_phase)
  );

  // ----------------------------------------------------------------
  // coil and speed pulse outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      drive_out <= '{coil_out_a: 1'b0, coil_out_b: 1'b0, speed_pulse_out: 1'b1};
      coil_enable <= 1'b0;
      pwm_on <= 1'b0;
    end else if (clk_en) begin
      drive_out.coil_out_a <= field_south_q;
      drive_out.coil_out_b <= !field_south_q;
      drive_out.speed_pulse_out <= field_south_q;
      coil_enable <= driving;
      pwm_on <= driving && on_phase;
    end
  end

  // open drain: pulled low only in north field
  assign speed_pulse_oe = !drive_out.speed_pulse_out;

endmodule : fan_commutation_lock_speed_ctrl

/* rtl/fan_ctrl_pkg.sv */
package fan_ctrl_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned CARRIER_FREQUENCY_HZ = 25_000;
  localparam int unsigned CARRIER_CYCLES = CLK_HZ / CARRIER_FREQUENCY_HZ;
  localparam int unsigned LOCK_DETECT_INTERVAL_MS = 300;
  localparam int unsigned LOCK_OFF_INTERVAL_MS = 4200;
  localparam int unsigned STANDBY_DELAY_MS = 25;
  localparam int unsigned CYCLES_PER_MS = CLK_HZ / 1000;

  // ----------------------------------------------------------------
  // speed command scale: level in millivolts
  // ----------------------------------------------------------------
  localparam int unsigned LEVEL_W = 12;
  localparam logic [LEVEL_W-1:0] RAMP_LOW_MV = 12'h1F4;
  localparam logic [LEVEL_W-1:0] RAMP_HIGH_MV = 12'h9C4;
  localparam logic [LEVEL_W-1:0] RAMP_SPAN_MV = RAMP_HIGH_MV - RAMP_LOW_MV;
  localparam logic [LEVEL_W-1:0] DIGITAL_HIGH_MV = 12'hBB8;
  localparam int unsigned PHASE_W = 9;
  localparam int unsigned AVG_SHIFT = 6;
  localparam int unsigned AVG_W = LEVEL_W + AVG_SHIFT;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_STOP = 4'h1,
    ST_RUN = 4'h2,
    ST_LOCK_OFF = 4'h4,
    ST_QUICK = 4'h8
  } drive_state_t;

  typedef struct packed {
    logic coil_out_a;
    logic coil_out_b;
    logic speed_pulse_out;
  } drive_out_t;

  typedef struct packed {
    logic digital_mode;
    logic digital_in;
    logic [LEVEL_W-1:0] level_mv;
  } speed_cmd_t;

endpackage : fan_ctrl_pkg

/* rtl/carrier_pwm.sv */
`timescale 1ns/1ps
module carrier_pwm
  import fan_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [LEVEL_W-1:0] level_mv,
  output logic on_phase
);

  localparam logic [PHASE_W-1:0] LAST_PHASE = PHASE_W'(CARRIER_CYCLES - 1);

  logic [PHASE_W-1:0] phase_q;
  logic [LEVEL_W-1:0] ramp_reference;

  // ----------------------------------------------------------------
  // carrier counter and ramp
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      phase_q <= '0;
    end else if (clk_en) begin
      if (phase_q == LAST_PHASE) begin
        phase_q <= '0;
      end else begin
        phase_q <= phase_q + PHASE_W'(1);
      end
    end
  end

  // ramp steps span/period mV per cycle from the low end
  assign ramp_reference = RAMP_LOW_MV + LEVEL_W'((32'(phase_q) * 32'(RAMP_SPAN_MV)) / CARRIER_CYCLES);

  always_ff @(posedge clk) begin
    if (rst) begin
      on_phase <= 1'b0;
    end else if (clk_en) begin
      on_phase <= (level_mv > ramp_reference);
    end
  end

endmodule : carrier_pwm

/* test/hall_magnet_model.sv */
`timescale 1ns/1ps
module hall_magnet_model #(
  parameter int unsigned HALF_TURN = 12
)(
  input wire logic clk,
  input wire logic spin,
  output logic hall_south,
  output logic hall_north
);
  // ----------------------------------------------------------------
  // rotor magnet: holds its pole while stalled
  // ----------------------------------------------------------------
  int unsigned cnt_q = 0;
  logic pole_q = 1'b0;
  always @(posedge clk) begin
    if (spin) begin
      cnt_q <= (cnt_q == HALF_TURN - 1) ? 0 : cnt_q + 1;
      if (cnt_q == HALF_TURN - 1) pole_q <= !pole_q;
    end
  end
  // flux inside the hysteresis band early in each half turn
  assign hall_south = pole_q && cnt_q > 2;
  assign hall_north = !pole_q && cnt_q > 2;
endmodule : hall_magnet_model

/* test/fan_ctrl_sva.sv */
`timescale 1ns/1ps
module fan_ctrl_sva
  import fan_ctrl_pkg::*;
#(
  parameter int unsigned LOCK_DETECT_CYCLES = 50,
  parameter int unsigned LOCK_OFF_CYCLES = 200,
  parameter int unsigned STANDBY_CYCLES = 20
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic hall_south,
  input wire logic hall_north,
  input speed_cmd_t speed_cmd,
  input drive_out_t drive_out,
  input wire logic speed_pulse_oe,
  input wire logic coil_enable,
  input wire logic pwm_on
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [26:0] stall_q, off_q, low_q;
  logic lo_cmd, hi_cmd;
  assign lo_cmd = !speed_cmd.digital_mode && speed_cmd.level_mv < RAMP_LOW_MV;
  assign hi_cmd = !speed_cmd.digital_mode && speed_cmd.level_mv >= RAMP_HIGH_MV;
  // ----------------------------------------------------------------
  // cycle counters
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst || !coil_enable || !$stable(drive_out)) stall_q <= '0;
    else if (clk_en) stall_q <= stall_q + 27'h1;
  end
  always_ff @(posedge clk) begin
    if (rst || coil_enable || lo_cmd || speed_cmd.digital_mode) off_q <= '0;
    else if (clk_en) off_q <= off_q + 27'h1;
  end
  always_ff @(posedge clk) begin
    if (rst || !lo_cmd) low_q <= '0;
    else if (clk_en) low_q <= low_q + 27'h1;
  end
  sequence north_s; clk_en && hall_north && !hall_south ##1 clk_en; endsequence
  sequence south_s; clk_en && hall_south && !hall_north ##1 clk_en; endsequence
  sequence hold_s; clk_en && hall_north == hall_south ##1 clk_en && hall_north == hall_south; endsequence
  north_drive_a: assert property (north_s |=> drive_out == 3'h2) else $error("north drive");
  south_drive_a: assert property (south_s |=> drive_out == 3'h5) else $error("south drive");
  field_hold_a: assert property (hold_s |=> $stable(drive_out)) else $error("field moved");
  pulse_oe_a: assert property (speed_pulse_oe == !drive_out.speed_pulse_out) else $error("pulse oe");
  lock_stop_a: assert property (stall_q <= LOCK_DETECT_CYCLES + 3) else $error("no lock stop");
  lock_off_a: assert property (off_q <= LOCK_OFF_CYCLES + 4) else $error("off too long");
  standby_stop_a: assert property (low_q >= STANDBY_CYCLES + 4 |-> !coil_enable) else $error("no standby");
  zero_duty_a: assert property (lo_cmd [*3] |-> !pwm_on) else $error("duty not zero");
  full_duty_a: assert property ((hi_cmd && coil_enable) [*3] |-> pwm_on) else $error("duty not full");
endmodule : fan_ctrl_sva

/* test/fan_commutation_lock_speed_ctrl_tb.sv */
`timescale 1ns/1ps
module fan_commutation_lock_speed_ctrl_tb;
  import fan_ctrl_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic spin = 1'b0;
  logic dig_run = 1'b0;
  speed_cmd_t speed_cmd = '{1'b0, 1'b0, 12'hBB8};
  logic hall_south, hall_north, speed_pulse_oe, coil_enable, pwm_on;
  drive_out_t drive_out;
  int err_total = 0;
  int checks = 0;
  int n;
  always #50 clk = !clk;
  always begin
    repeat (50) @(posedge clk);
    #1 speed_cmd.digital_in = dig_run && !speed_cmd.digital_in;
  end
  hall_magnet_model u_magnet (.clk(clk), .spin(spin), .hall_south(hall_south), .hall_north(hall_north));
  fan_commutation_lock_speed_ctrl #(.LOCK_DETECT_CYCLES(50), .LOCK_OFF_CYCLES(200), .STANDBY_CYCLES(20)) u_dut (
    .clk(clk), .rst(rst), .clk_en(1'b1), .hall_south(hall_south), .hall_north(hall_north),
    .speed_cmd(speed_cmd), .drive_out(drive_out), .speed_pulse_oe(speed_pulse_oe),
    .coil_enable(coil_enable), .pwm_on(pwm_on));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : step
  task automatic cmp_bits(input string what, input logic [2:0] exp, input logic [2:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_bits
  task automatic cmp_range(input string what, input int lo, input int hi, input int got);
    checks++;
    if (got < lo || got > hi) begin
      err_total++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask : cmp_range
  task automatic wait_coil(input logic v, input int bound);
    n = 0;
    while (coil_enable !== v) begin
      if (n == bound) begin
        cmp_bits("coil_enable wait", {2'h0, v}, {2'h0, coil_enable});
        close_out();
      end
      step(1);
      n++;
    end
  endtask : wait_coil
  task automatic duty(input logic [11:0] mv, input int lo, input int hi);
    int on;
    on = 0;
    speed_cmd.level_mv = mv;
    step(400);
    for (int i = 0; i < 400; i++) begin
      on += int'(pwm_on === 1'b1);
      step(1);
    end
    cmp_range("pwm_on cycles", lo, hi, on);
  endtask : duty
  task automatic close_out;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_field;
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 30 && (p ? hall_south : hall_north) !== 1'b1; i++) step(1);
      if ((p ? hall_south : hall_north) !== 1'b1) begin
        cmp_bits("hall wait", 3'h1, 3'h0);
        close_out();
      end
      step(4);
      cmp_bits("drive_out", p ? 3'h5 : 3'h2, drive_out);
      cmp_bits("speed_pulse_oe", {2'h0, !p[0]}, {2'h0, speed_pulse_oe});
    end
  endtask : t_field
  task automatic t_duty;
    duty(12'h1F4, 0, 0);
    for (int k = 0; k < 4; k++) duty(12'h3E8 + 12'(k) * 12'h1F4, 100 * k + 98, 100 * k + 102);
    speed_cmd.digital_mode = 1'b1;
    dig_run = 1'b1;
    duty(12'h000, 150, 250);
    // back to full-speed level before leaving digital mode, else standby follows
    speed_cmd.level_mv = 12'hBB8;
    speed_cmd.digital_mode = 1'b0;
    dig_run = 1'b0;
  endtask : t_duty
  task automatic t_lock;
    spin = 1'b0;
    wait_coil(1'b0, 60);
    cmp_range("lock detect", 30, 55, n);
    wait_coil(1'b1, 220);
    cmp_range("lock off", 195, 205, n);
    wait_coil(1'b0, 60);
    cmp_range("relock", 45, 55, n);
    spin = 1'b1;
    wait_coil(1'b1, 220);
    step(150);
    cmp_bits("coil_enable", 3'h1, {2'h0, coil_enable});
  endtask : t_lock
  task automatic t_standby;
    speed_cmd.level_mv = 12'h12C;
    wait_coil(1'b0, 30);
    cmp_range("standby delay", 18, 25, n);
    step(300);
    cmp_bits("coil_enable", 3'h0, {2'h0, coil_enable});
    speed_cmd.level_mv = 12'h5DC;
    wait_coil(1'b1, 6);
    cmp_range("quick start", 0, 5, n);
  endtask : t_standby
  initial begin
    step(3);
    rst = 1'b0;
    spin = 1'b1;
    step(20);
    t_field();
    t_duty();
    t_lock();
    t_standby();
    close_out();
  end
endmodule : fan_commutation_lock_speed_ctrl_tb

bind fan_commutation_lock_speed_ctrl fan_ctrl_sva #(.LOCK_DETECT_CYCLES(LOCK_DETECT_CYCLES),
  .LOCK_OFF_CYCLES(LOCK_OFF_CYCLES), .STANDBY_CYCLES(STANDBY_CYCLES)) u_sva (.clk(clk), .rst(rst),
  .clk_en(clk_en), .hall_south(hall_south), .hall_north(hall_north), .speed_cmd(speed_cmd),
  .drive_out(drive_out), .speed_pulse_oe(speed_pulse_oe), .coil_enable(coil_enable), .pwm_on(pwm_on));
